// ---- fan_fan_pulse_input_pkg.sv ----
/*
 * Constants for the fan period measurement block: register indices,
 * field positions, reset values, timing counts and the channel state.
 * Assumes a 100 MHz APB clock; byte address is four times the index.
 */
package fan_fan_pulse_input_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_HZ = 100_000_000;
    // On-chip measurement oscillator, 11.11 us per count
    localparam int unsigned OSC_HZ = 90_000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / OSC_HZ;
    localparam int unsigned TICK_W = 11;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Counter
    localparam int unsigned COUNT_W = 16;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam int unsigned FAN_CHANNELS = 4;

    ////////////////////////////////////////////////////////////////////////
    // Bus
    localparam int unsigned PADDR_W = 12;
    localparam int unsigned IDX_W = 8;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Register indices
    localparam logic [IDX_W-1:0] IDX_FAN1_COUNT_LOW = 8'h28;
    localparam logic [IDX_W-1:0] IDX_FAN1_COUNT_HIGH = 8'h29;
    localparam logic [IDX_W-1:0] IDX_FAN2_COUNT_LOW = 8'h2A;
    localparam logic [IDX_W-1:0] IDX_FAN2_COUNT_HIGH = 8'h2B;
    localparam logic [IDX_W-1:0] IDX_FAN3_COUNT_LOW = 8'h2C;
    localparam logic [IDX_W-1:0] IDX_FAN3_COUNT_HIGH = 8'h2D;
    localparam logic [IDX_W-1:0] IDX_FAN4_COUNT_LOW = 8'h2E;
    localparam logic [IDX_W-1:0] IDX_FAN4_COUNT_HIGH = 8'h2F;
    localparam logic [IDX_W-1:0] IDX_ACOUSTIC_ENHANCE_ONE = 8'h62;
    localparam logic [IDX_W-1:0] IDX_PULSES_PER_REV_SELECT = 8'h7B;
    localparam logic [IDX_W-1:0] IDX_DRIVE_MODE_CONFIG = 8'h80;

    ////////////////////////////////////////////////////////////////////////
    // Fields and reset values
    localparam int unsigned SYNC_BIT = 4;
    localparam int unsigned LOW_FREQ_BIT = 2;
    localparam int unsigned TWO_WIRE_LSB = 4;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] ACOUSTIC_RESET = 8'h00;
    localparam logic [7:0] PPR_RESET = 8'h55;
    localparam logic [7:0] MODE_RESET = 8'h00;

    typedef enum logic {MEAS_WAIT, MEAS_COUNT} meas_state_e;

endpackage : fan_fan_pulse_input_pkg

// ---- fan_fan_pulse_input_period_measure.sv ----
/*
 * Fan period measurement: four channels, each gating a 90 kHz tick into
 * a saturating 16-bit counter over N tachometer periods, plus an APB
 * slave holding the readings and the steering registers.
 * Assumes tachometer and sensed-current inputs are asynchronous pins and
 * the drive levels come from the PWM logic on pclk.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// One measurement channel
module fan_period_channel
    import fan_fan_pulse_input_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Measurement control
    input wire logic tick,
    input wire logic pulse_level,
    input wire logic edge_accept,
    input wire logic channel_enable,
    input wire logic [1:0] periods_code,
    // Result
    output logic [COUNT_W-1:0] result
);

    meas_state_e state_reg;
    logic pulse_prev_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [1:0] periods_seen_reg;
    logic rise;
    logic done;

    assign rise = pulse_level && !pulse_prev_reg && edge_accept;
    assign done = rise && (periods_seen_reg == periods_code);

    // Idle level of a fan_pulse_input line is high; avoids a false edge after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_prev_reg <= 1'b1;
        end else begin
            pulse_prev_reg <= pulse_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= MEAS_WAIT;
            periods_seen_reg <= 2'b00;
        end else if (!channel_enable) begin
            state_reg <= MEAS_WAIT;
            periods_seen_reg <= 2'b00;
        end else begin
            case (state_reg)
                MEAS_WAIT: begin
                    periods_seen_reg <= 2'b00;
                    if (rise) begin
                        state_reg <= MEAS_COUNT;
                    end
                end
                MEAS_COUNT: begin
                    if (done || count_reg == COUNT_MAX) begin
                        state_reg <= MEAS_WAIT;
                    end else if (rise) begin
                        periods_seen_reg <= periods_seen_reg + 2'b01;
                    end
                end
                default: begin
                    state_reg <= MEAS_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (state_reg != MEAS_COUNT) begin
            count_reg <= '0;
        end else if (tick && count_reg != COUNT_MAX) begin
            count_reg <= count_reg + COUNT_ONE;
        end
    end

    // Stalled fan publishes full scale and waits for the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= {COUNT_RESET, COUNT_RESET};
        end else if (state_reg == MEAS_COUNT && channel_enable &&
                     (done || count_reg == COUNT_MAX)) begin
            result <= count_reg;
        end
    end

endmodule : fan_period_channel

////////////////////////////////////////////////////////////////////////////
// Top: pins, tick, channels and register file
module fan_fan_pulse_input_period_measure
    import fan_fan_pulse_input_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fan pulse pins
    input wire logic fan_pulse_in_one,
    input wire logic fan_pulse_in_two,
    input wire logic fan_pulse_in_three,
    input wire logic fan_pulse_in_four,
    // Sensed current comparator outputs, one per fan
    input wire logic [FAN_CHANNELS-1:0] sensed_current_input,
    // Drive levels from the PWM logic, high while the fan is on
    input wire logic drive_out_one,
    input wire logic drive_out_two,
    input wire logic drive_out_three
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [FAN_CHANNELS-1:0] pulse_meta_reg;
    logic [FAN_CHANNELS-1:0] pulse_sync_reg;
    logic [FAN_CHANNELS-1:0] sense_meta_reg;
    logic [FAN_CHANNELS-1:0] sense_sync_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_meta_reg <= '1;
            pulse_sync_reg <= '1;
            sense_meta_reg <= '0;
            sense_sync_reg <= '0;
        end else begin
            pulse_meta_reg <= {fan_pulse_in_four, fan_pulse_in_three,
                               fan_pulse_in_two, fan_pulse_in_one};
            pulse_sync_reg <= pulse_meta_reg;
            sense_meta_reg <= sensed_current_input;
            sense_sync_reg <= sense_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement tick
    logic [TICK_W-1:0] tick_count_reg;
    logic tick;

    assign tick = (tick_count_reg == TICK_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count_reg <= '0;
        end else if (tick) begin
            tick_count_reg <= '0;
        end else begin
            tick_count_reg <= tick_count_reg + TICK_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Steering registers
    logic [7:0] acoustic_enhance_one_reg;
    logic [7:0] pulses_per_rev_select_reg;
    logic [7:0] drive_mode_config_reg;
    logic sync_to_three;
    logic low_freq_mode;
    logic [FAN_CHANNELS-1:0] two_wire_sel;

    assign sync_to_three = acoustic_enhance_one_reg[SYNC_BIT];
    assign low_freq_mode = drive_mode_config_reg[LOW_FREQ_BIT];
    assign two_wire_sel =
        drive_mode_config_reg[TWO_WIRE_LSB +: FAN_CHANNELS];

    ////////////////////////////////////////////////////////////////////////
    // Channel steering
    logic [FAN_CHANNELS-1:0] drive_on;
    logic [FAN_CHANNELS-1:0] pulse_level;
    logic [FAN_CHANNELS-1:0] edge_accept;
    logic [FAN_CHANNELS-1:0] channel_enable;
    logic [COUNT_W-1:0] result [FAN_CHANNELS];

    assign drive_on[0] = drive_out_one;
    assign drive_on[1] = sync_to_three ? drive_out_three : drive_out_two;
    assign drive_on[2] = drive_out_three;
    assign drive_on[3] = drive_out_three;

    genvar ch;
    generate
        for (ch = 0; ch < FAN_CHANNELS; ch++) begin : g_chan
            assign pulse_level[ch] = two_wire_sel[ch] ?
                sense_sync_reg[ch] : pulse_sync_reg[ch];
            assign edge_accept[ch] = !low_freq_mode || drive_on[ch];
            assign channel_enable[ch] = !two_wire_sel[ch] || low_freq_mode;

            fan_period_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick),
                .pulse_level(pulse_level[ch]),
                .edge_accept(edge_accept[ch]),
                .channel_enable(channel_enable[ch]),
                .periods_code(pulses_per_rev_select_reg[2*ch +: 2]),
                .result(result[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic [IDX_W-1:0] idx;
    logic addr_ok;
    logic setup;
    logic access;
    logic is_count;
    logic [1:0] count_ch;
    logic count_high;

    assign idx = paddr[IDX_W+1:2];
    assign addr_ok = (paddr[1:0] == 2'b00) &&
                     (paddr[PADDR_W-1:IDX_W+2] == '0);
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign is_count = (idx >= IDX_FAN1_COUNT_LOW) &&
                      (idx <= IDX_FAN4_COUNT_HIGH);
    assign count_ch = idx[2:1];
    assign count_high = idx[0];

    ////////////////////////////////////////////////////////////////////////
    // High byte freeze
    logic [7:0] hold_high_reg [FAN_CHANNELS];
    logic [FAN_CHANNELS-1:0] frozen_reg;

    // low read freezes high byte; taken in setup with the data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frozen_reg <= '0;
            for (int i = 0; i < FAN_CHANNELS; i++) begin
                hold_high_reg[i] <= COUNT_RESET;
            end
        end else if (setup && !pwrite && addr_ok && is_count) begin
            if (!count_high) begin
                hold_high_reg[count_ch] <= result[count_ch][15:8];
                frozen_reg[count_ch] <= 1'b1;
            end else begin
                frozen_reg[count_ch] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    logic [7:0] rd_byte;
    logic rd_hit;

    always_comb begin
        rd_byte = COUNT_RESET;
        rd_hit = addr_ok;
        if (is_count) begin
            if (!count_high) begin
                rd_byte = result[count_ch][7:0];
            end else if (frozen_reg[count_ch]) begin
                rd_byte = hold_high_reg[count_ch];
            end else begin
                rd_byte = result[count_ch][15:8];
            end
        end else begin
            case (idx)
                IDX_ACOUSTIC_ENHANCE_ONE: begin
                    rd_byte = acoustic_enhance_one_reg;
                end
                IDX_PULSES_PER_REV_SELECT: begin
                    rd_byte = pulses_per_rev_select_reg;
                end
                IDX_DRIVE_MODE_CONFIG: begin
                    rd_byte = drive_mode_config_reg;
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait-free access phase, all outputs registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RD_ZERO;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !rd_hit;
            prdata <= (!pwrite && rd_hit) ? {24'h00_0000, rd_byte} : RD_ZERO;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; counts are read-only and writes to them are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acoustic_enhance_one_reg <= ACOUSTIC_RESET;
            pulses_per_rev_select_reg <= PPR_RESET;
            drive_mode_config_reg <= MODE_RESET;
        end else if (access && pwrite && addr_ok) begin
            case (idx)
                IDX_ACOUSTIC_ENHANCE_ONE: begin
                    acoustic_enhance_one_reg <= pwdata[7:0];
                end
                IDX_PULSES_PER_REV_SELECT: begin
                    pulses_per_rev_select_reg <= pwdata[7:0];
                end
                IDX_DRIVE_MODE_CONFIG: begin
                    drive_mode_config_reg <= pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

endmodule : fan_fan_pulse_input_period_measure

// ---- fan_fan_pulse_input_asserts.sv ----
/*
 * Port checker for the fan period block: APB timing and decoding.
 * Assumes a bind onto fan_fan_pulse_input_period_measure, one clock domain.
 */
`timescale 1ns/1ps
module fan_fan_pulse_input_asserts
    import fan_fan_pulse_input_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic setup;
    logic bad;
    logic cnt_idx;
    assign setup = psel && !penable;
    // Only one unmapped index sampled, plus misalignment
    assign bad = (paddr[1:0] != 2'b00) || (paddr[9:2] == 8'h30);
    assign cnt_idx = (paddr[11:5] == 7'b000_0101) && (paddr[1:0] == 2'b00);
    ////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (setup |=> pready && penable)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    a_byte_wide_data: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_bad_addr_err: assert property (setup && bad |=> pslverr)
        else $error("bad address not refused");
    a_count_no_err: assert property (setup && cnt_idx |=> !pslverr)
        else $error("reading register refused");
endmodule : fan_fan_pulse_input_asserts

// ---- fan_pulse_model.sv ----
/*
 * Fan tachometer model: square wave of a set period in pclk cycles.
 * Assumes an open-drain line with pull-up: a stopped fan reads high.
 */
`timescale 1ns/1ps
module fan_pulse_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Period in pclk cycles, zero stops the fan
    input wire logic [15:0] period,
    // Fan_pulse_input line
    output logic pulse
);
    logic [15:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_reg <= 16'h0000;
        else if (period == 16'h0000 || cnt_reg >= period - 16'h0001)
            cnt_reg <= 16'h0000;
        else
            cnt_reg <= cnt_reg + 16'h0001;
    end
    // Idle at pull-up level, no edge when stopped
    assign pulse = (period == 16'h0000) || (cnt_reg < (period >> 1));
endmodule : fan_pulse_model

// ---- tb_top.sv ----
/*
 * Self-checking bench: APB register tests and period measurements.
 * Assumes the fan model above and the checker bound below.
 */
`timescale 1ns/1ps
module tb_top
    import fan_fan_pulse_input_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] sensed;
    logic drv1, drv2, drv3, fan_pulse;
    logic [15:0] period;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    fan_fan_pulse_input_period_measure uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fan_pulse_in_one(fan_pulse),
        .fan_pulse_in_two(fan_pulse), .fan_pulse_in_three(fan_pulse),
        .fan_pulse_in_four(fan_pulse), .sensed_current_input(sensed),
        .drive_out_one(drv1), .drive_out_two(drv2), .drive_out_three(drv3));
    fan_pulse_model u_fan (.pclk(pclk), .presetn(presetn),
        .period(period), .pulse(fan_pulse));
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic cmp_eq(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_eq
    task automatic cmp_rng(input logic [31:0] got, input int lo, input int hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t got %h outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : cmp_rng
    // Low byte first, then high of the same reading
    task automatic rd_fan(input int k, input int lo, input int hi);
        xfer(1'b0, 8'h28 + 8'(2 * k), 32'h0000_0000);
        cmp_rng(rd, lo, hi);
        xfer(1'b0, 8'h29 + 8'(2 * k), 32'h0000_0000);
        cmp_eq(rd, 32'h0000_0000);
    endtask : rd_fan
    task automatic wait_fan(input int k, input int lo, input int hi);
        for (int i = 0; i < 300; i++) begin
            xfer(1'b0, 8'h28 + 8'(2 * k), 32'h0000_0000);
            if ((rd >= lo && rd <= hi) === 1'b1) break;
            repeat (100) @(posedge pclk);
        end
    endtask : wait_fan
    task automatic final_report;
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    // Whole run is about 73k cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            final_report();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, sensed, period} = '0;
        {drv1, drv2, drv3} = 3'b111;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            xfer(1'b0, 8'h28 + 8'(k), 32'h0000_0000);
            cmp_eq(rd, 32'h0000_0000);
        end
        xfer(1'b0, IDX_PULSES_PER_REV_SELECT, 32'h0000_0000);
        cmp_eq(rd, 32'h0000_0055);
        xfer(1'b0, 8'h30, 32'h0000_0000);
        cmp_eq({31'h0, er}, 32'h0000_0001);
        xfer(1'b1, 8'h28, 32'h0000_00FF);
        xfer(1'b0, 8'h28, 32'h0000_0000);
        cmp_eq(rd, 32'h0000_0000);
        $display("Test registers done");
        // Codes 00..11 on fans one to four, five ticks per period
        xfer(1'b1, IDX_PULSES_PER_REV_SELECT, 32'h0000_00E4);
        period <= 16'd5555;
        wait_fan(3, 19, 21);
        for (int k = 0; k < 4; k++) begin
            rd_fan(k, 5 * k + 4, 5 * k + 6);
        end
        $display("Test pulse counts done");
        // Low-frequency mode, sync on, drive three off, period doubled
        xfer(1'b1, IDX_DRIVE_MODE_CONFIG, 32'h0000_0004);
        xfer(1'b1, IDX_ACOUSTIC_ENHANCE_ONE, 32'h0000_0010);
        xfer(1'b0, IDX_ACOUSTIC_ENHANCE_ONE, 32'h0000_0000);
        cmp_eq(rd, 32'h0000_0010);
        drv3 <= 1'b0;
        period <= 16'd11110;
        wait_fan(0, 9, 11);
        repeat (34000) @(posedge pclk);
        rd_fan(0, 9, 11);
        rd_fan(1, 9, 11);
        rd_fan(2, 14, 16);
        rd_fan(3, 19, 21);
        $display("Test drive gating done");
        final_report();
    end
endmodule : tb_top

bind fan_fan_pulse_input_period_measure fan_fan_pulse_input_asserts u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
